//--- sim/bimon_chk.sv
// Concurrent assertions on the ports of the bus illegal access monitor
`timescale 1ns/10ps
`default_nettype none
module bimon_chk (
  input wire logic                  clk_i,
  input wire logic                  resetn_i,
  input wire logic                  rtc_reset_i,
  input wire logic           [31:0] reg_addr_i,
  input wire logic                  reg_we_i,
  input wire logic                  reg_re_i,
  input wire logic           [15:0] reg_rdata_o,
  input wire logic                  cpu_valid_i,
  input wire bimon_pkg::bimon_req_s cpu_req_i,
  input wire logic                  cpu_ready_o,
  input wire bimon_pkg::bimon_rsp_s cpu_rsp_o,
  input wire logic                  fwd_valid_o,
  input wire bimon_pkg::bimon_req_s fwd_req_o,
  input wire logic                  fwd_abort_o,
  input wire logic                  maskable_irq_line_o
);
  import bimon_pkg::*;
  logic       take;
  logic       rsv;
  logic [3:0] rtc_hist;
  assign take = cpu_valid_i && cpu_ready_o;
  assign rsv  = cpu_req_i.addr[31:24] == 8'h0E
             || cpu_req_i.addr[31:25] == 7'h04;
  // RTC reset history, so sticky checks allow for its clearing
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rtc_hist <= 4'h0;
    else rtc_hist <= {rtc_hist[2:0], rtc_reset_i};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_rsv_done;
    take && rsv |-> ##2 cpu_rsp_o.done;
  endproperty
  a_rsv_done: assert property (p_rsv_done)
    else $error("reserved access not ended two cycles after take");
  property p_rsv_read;
    take && rsv && !cpu_req_i.write
      |=> maskable_irq_line_o ##1 cpu_rsp_o.bus_error;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("reserved read without interrupt and bus error");
  property p_rsv_write;
    take && rsv && cpu_req_i.write |-> ##2 !cpu_rsp_o.bus_error;
  endproperty
  a_rsv_write: assert property (p_rsv_write)
    else $error("reserved write answered with bus error");
  property p_dummy;
    take && rsv |=> !fwd_valid_o [*2];
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("reserved access forwarded to the bus");
  property p_fwd;
    take && !rsv |=> fwd_valid_o && fwd_req_o == $past(cpu_req_i);
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("legal access not forwarded unchanged");
  property p_fwd_hold;
    fwd_valid_o && $past(fwd_valid_o) |-> $stable(fwd_req_o);
  endproperty
  a_fwd_hold: assert property (p_fwd_hold)
    else $error("forwarded request changed while in progress");
  property p_abort;
    fwd_abort_o |-> cpu_rsp_o.done && cpu_rsp_o.bus_error;
  endproperty
  a_abort: assert property (p_abort)
    else $error("discarded cycle without bus error");
  property p_abort_src;
    fwd_abort_o |-> $past(fwd_req_o.io_space) && !$past(fwd_req_o.write);
  endproperty
  a_abort_src: assert property (p_abort_src)
    else $error("timeout on a write or non io read");
  property p_sticky;
    $fell(maskable_irq_line_o)
      |-> $past(reg_we_i) || $past(reg_we_i, 2) || |rtc_hist;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("interrupt line dropped without clearing");
  property p_rsvd_zero;
    reg_re_i && reg_addr_i == BIMON_OFF_IRQ |=> reg_rdata_o[15:2] == 14'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("status upper bits not zero");
  property p_rtc;
    rtc_hist == 4'hF |-> !maskable_irq_line_o;
  endproperty
  a_rtc: assert property (p_rtc)
    else $error("interrupt line high during rtc reset");
endmodule : bimon_chk
`default_nettype wire

//--- sim/bimon_target.sv
// Bus target model answering forwarded cycles after a set wait
`timescale 1ns/10ps
`default_nettype none
module bimon_target (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       fwd_valid_i,
  input  wire logic [7:0] wait_i,
  output logic            ext_ready_o
);
  logic [7:0] cnt;
  // A wait of FF never answers, which is how a deadlock is made
  assign ext_ready_o = fwd_valid_i && cnt == wait_i && wait_i != 8'hFF;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) cnt <= 8'h00;
    else cnt <= (fwd_valid_i && !ext_ready_o) ? cnt + 8'h01 : 8'h00;
  end
endmodule : bimon_target
`default_nettype wire

//--- sim/bimon_top_tb.sv
// Self-checking testbench of the bus illegal access monitor
`timescale 1ns/10ps
`default_nettype none
module bimon_top_tb;
  import bimon_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, rtc = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wdata = 16'h0;
  logic        we = 1'b0, re = 1'b0, valid = 1'b0;
  bimon_req_s  req = '0;
  logic [7:0]  dly = 8'h00;
  logic [15:0] rdata;
  logic        ready, fvalid, eready, abort, irq;
  bimon_rsp_s  rsp;
  bimon_req_s  freq;
  int          mismatches = 0;
  int          checked = 0;
  logic [31:0] offs [5] = '{BIMON_OFF_TMO_SET, BIMON_OFF_TMO_COUNT,
    BIMON_OFF_ERR_LO, BIMON_OFF_ERR_HI, BIMON_OFF_IRQ};
  logic [31:0] bnd [8] = '{32'h07FF_FFFF, 32'h0800_0000, 32'h09FF_FFFF,
    32'h0A00_0000, 32'h0DFF_FFFF, 32'h0E00_0000, 32'h0EFF_FFFF, 32'h0F00_0000};
  logic [7:0]  rsvx = 8'b0110_0110;

  always #50 clk = ~clk;

  bimon_top DUT (.clk_i(clk), .resetn_i(rstn), .rtc_reset_i(rtc),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .cpu_valid_i(valid), .cpu_req_i(req),
    .cpu_ready_o(ready), .cpu_rsp_o(rsp), .fwd_valid_o(fvalid),
    .fwd_req_o(freq), .ext_ready_i(eready), .fwd_abort_o(abort),
    .maskable_irq_line_o(irq));
  bimon_target u_target (.clk_i(clk), .resetn_i(rstn), .fwd_valid_i(fvalid),
    .wait_i(dly), .ext_ready_o(eready));

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    chk($sformatf("reg %h", a), rdata, exp);
  endtask : rd

  // Errors e = {bus error, abort}; latency n counted from the take edge
  task automatic cpu(input logic [31:0] a, input logic w, io,
                     input logic [7:0] d, input logic [1:0] e, input int n);
    int k;
    @(posedge clk);
    req <= '{write: w, io_space: io, addr: a};
    dly <= d;
    valid <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 50 && ready !== 1'b1; k++) @(posedge clk);
    valid <= 1'b0;
    for (k = 1; k < 200; k++) begin
      @(posedge clk);
      if (rsp.done === 1'b1) break;
    end
    chk("bus error", {15'h0, rsp.bus_error}, {15'h0, e[1]});
    chk("abort", {15'h0, abort}, {15'h0, e[0]});
    chk("latency", 16'(k), 16'(n));
  endtask : cpu

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 16'h0000);
    cpu(32'h0E00_0010, 1'b0, 1'b0, 8'h00, 2'b10, 2);
    chk("irq", {15'h0, irq}, 16'h0001);
    rd(BIMON_OFF_IRQ, 16'h0001);
    rd(BIMON_OFF_ERR_LO, 16'h0010);
    rd(BIMON_OFF_ERR_HI, 16'h0E00);
    cpu(32'h09FF_FFFF, 1'b1, 1'b0, 8'h00, 2'b00, 2);
    rd(BIMON_OFF_ERR_LO, 16'hFFFF);
    rd(BIMON_OFF_ERR_HI, 16'h09FF);
    // Both edges of each reserved window, read back to back
    foreach (bnd[i]) begin
      cpu(bnd[i], 1'b0, 1'b0, 8'h01, {rsvx[i], 1'b0}, rsvx[i] ? 2 : 3);
    end
    wr(BIMON_OFF_IRQ, 16'h0001);
    rd(BIMON_OFF_IRQ, 16'h0000);
    chk("irq", {15'h0, irq}, 16'h0000);
    wr(BIMON_OFF_ERR_LO, 16'hA5C3);
    rd(BIMON_OFF_ERR_LO, 16'hA5C3);
    wr(BIMON_OFF_ERR_HI, 16'h5A3C);
    rd(BIMON_OFF_ERR_HI, 16'h5A3C);
    wr(BIMON_OFF_TMO_COUNT, 16'h1234);
    rd(BIMON_OFF_TMO_COUNT, 16'h1234);
    wr(BIMON_OFF_TMO_SET, 16'h0005);
    rd(BIMON_OFF_TMO_SET, 16'h0005);
    cpu(32'h1000_0020, 1'b0, 1'b1, 8'hFF, 2'b11, 6);
    rd(BIMON_OFF_IRQ, 16'h0002);
    rd(BIMON_OFF_ERR_LO, 16'h0020);
    rd(BIMON_OFF_ERR_HI, 16'h1000);
    wr(BIMON_OFF_IRQ, 16'h0002);
    rd(BIMON_OFF_IRQ, 16'h0000);
    cpu(32'h1000_0040, 1'b1, 1'b1, 8'h0A, 2'b00, 12);
    cpu(32'h1000_0060, 1'b0, 1'b1, 8'h04, 2'b00, 6);
    // Count bit 0 is ignored, so limit field 3 fires at count 6
    wr(BIMON_OFF_TMO_SET, 16'h0007);
    cpu(32'h1000_0070, 1'b0, 1'b1, 8'hFF, 2'b11, 8);
    wr(BIMON_OFF_TMO_SET, 16'h0004);
    cpu(32'h1000_0080, 1'b0, 1'b1, 8'h0A, 2'b00, 12);
    rd(BIMON_OFF_ERR_LO, 16'h0070);
    rd(BIMON_OFF_IRQ, 16'h0002);
    rtc <= 1'b1;
    repeat (5) @(posedge clk);
    rtc <= 1'b0;
    repeat (3) @(posedge clk);
    foreach (offs[i]) rd(offs[i], 16'h0000);
    stop_test();
  end
endmodule : bimon_top_tb

bind bimon_top bimon_chk u_chk (.clk_i, .resetn_i, .rtc_reset_i, .reg_addr_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .cpu_valid_i, .cpu_req_i, .cpu_ready_o,
  .cpu_rsp_o, .fwd_valid_o, .fwd_req_o, .fwd_abort_o, .maskable_irq_line_o);
`default_nettype wire

//--- verilog/bimon_pkg.sv
// Shared constants and types of the bus illegal access monitor
`default_nettype none
package bimon_pkg;

  // ----------------------------------------------------------------------
  // Register offsets in the unit's address map
  // ----------------------------------------------------------------------
  localparam logic [31:0] BIMON_OFF_TMO_SET   = 32'h0F00_1000;
  localparam logic [31:0] BIMON_OFF_TMO_COUNT = 32'h0F00_1002;
  localparam logic [31:0] BIMON_OFF_ERR_LO    = 32'h0F00_1004;
  localparam logic [31:0] BIMON_OFF_ERR_HI    = 32'h0F00_1006;
  localparam logic [31:0] BIMON_OFF_IRQ       = 32'h0F00_1008;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned BIMON_TMO_EN_BIT    = 0;
  localparam int unsigned BIMON_IRQ_RSV_BIT   = 0;
  localparam int unsigned BIMON_IRQ_TMO_BIT   = 1;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] BIMON_RST_TMO_SET   = 16'h0000;
  localparam logic [15:0] BIMON_RST_TMO_COUNT = 16'h0000;
  localparam logic [31:0] BIMON_RST_ERR_ADDR  = 32'h0000_0000;
  localparam logic [15:0] BIMON_RST_RDATA     = 16'h0000;

  // ----------------------------------------------------------------------
  // Reserved physical address windows
  // ----------------------------------------------------------------------
  localparam logic [31:0] BIMON_RSV_A_LO      = 32'h0E00_0000;
  localparam logic [31:0] BIMON_RSV_A_HI      = 32'h0EFF_FFFF;
  localparam logic [31:0] BIMON_RSV_B_LO      = 32'h0800_0000;
  localparam logic [31:0] BIMON_RSV_B_HI      = 32'h09FF_FFFF;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        write;
    logic        io_space;
    logic [31:0] addr;
  } bimon_req_s;

  typedef struct packed {
    logic done;
    logic bus_error;
  } bimon_rsp_s;

  typedef enum logic [1:0] {
    BIMON_IDLE,
    BIMON_FWD,
    BIMON_DUMMY
  } bimon_state_e;

  typedef struct packed {
    bimon_state_e state;
    logic [1:0]   rtc_sync;
    bimon_req_s   req;
    logic [15:0]  tmo_set;
    logic [31:0]  fault_address;
    logic         timeout_error_flag;
    logic         reserved_space_error_flag;
    logic [15:0]  rdata;
    bimon_rsp_s   rsp;
    logic         abort;
  } bimon_core_s;

  typedef struct packed {
    logic [15:0] timeout_count;
  } bimon_timer_s;

endpackage : bimon_pkg
`default_nettype wire

//--- verilog/bimon_timer.sv
// Timeout counter of the bus illegal access monitor
`timescale 1ns/10ps
`default_nettype none
module bimon_timer (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        clear_i,
  input  wire logic        run_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [15:0] limit_i,
  output logic      [15:0] count_o,
  output logic             hit_o
);
  import bimon_pkg::*;

  bimon_timer_s q;
  bimon_timer_s next_q;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_comb begin
    next_q = q;
    if (clear_i) begin
      next_q.timeout_count = BIMON_RST_TMO_COUNT;
    end else if (wr_i) begin
      next_q.timeout_count = wdata_i;
    end else if (run_i) begin
      next_q.timeout_count = q.timeout_count + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Bit 0 is ignored, so the limit has a granularity of two cycles
  assign hit_o   = (q.timeout_count[15:1] == limit_i[15:1]);
  assign count_o = q.timeout_count;

endmodule : bimon_timer
`default_nettype wire

//--- verilog/bimon_top.sv
// Bus illegal access monitor: timeout and reserved-space detection
`timescale 1ns/10ps
`default_nettype none
module bimon_top (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  rtc_reset_i,
  // Register port
  input  wire logic           [31:0] reg_addr_i,
  input  wire logic           [15:0] reg_wdata_i,
  input  wire logic                  reg_we_i,
  input  wire logic                  reg_re_i,
  output logic                [15:0] reg_rdata_o,
  // Processor request side
  input  wire logic                  cpu_valid_i,
  input  wire bimon_pkg::bimon_req_s cpu_req_i,
  output logic                       cpu_ready_o,
  output bimon_pkg::bimon_rsp_s      cpu_rsp_o,
  // Forwarded cycle toward the system bus targets
  output logic                       fwd_valid_o,
  output bimon_pkg::bimon_req_s      fwd_req_o,
  input  wire logic                  ext_ready_i,
  output logic                       fwd_abort_o,
  // Interrupt toward the core
  output logic                       maskable_irq_line_o
);
  import bimon_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic in_window(input logic [31:0] a,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
    in_window = (a >= lo) && (a <= hi);
  endfunction : in_window

  function automatic logic reserved_addr(input logic [31:0] a);
    reserved_addr = in_window(a, BIMON_RSV_A_LO, BIMON_RSV_A_HI)
                  | in_window(a, BIMON_RSV_B_LO, BIMON_RSV_B_HI);
  endfunction : reserved_addr

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  bimon_core_s q;
  bimon_core_s next_q;

  logic        rtc_clr;
  logic        accept;
  logic        acc_reserved;
  logic        start_timing;
  logic        timing;
  logic        tmo_hit;
  logic        tmo_fire;
  logic [15:0] tmo_count;
  logic        wr_set;
  logic        wr_count;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_irq;
  logic        rd_any;
  logic        capture;
  logic [15:0] irq_word;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign rtc_clr      = q.rtc_sync[1];
  assign accept       = cpu_valid_i && (q.state == BIMON_IDLE);
  assign acc_reserved = reserved_addr(cpu_req_i.addr);

  // Only reads to I/O or PCI space are timed; write hangs go unreported
  assign start_timing = accept && !acc_reserved && !cpu_req_i.write
                      && cpu_req_i.io_space;
  assign timing       = (q.state == BIMON_FWD) && !q.req.write
                      && q.req.io_space;

  // Ready in the same cycle as the match completes the access normally
  assign tmo_fire     = timing && !ext_ready_i && tmo_hit
                      && q.tmo_set[BIMON_TMO_EN_BIT];

  assign capture      = (accept && acc_reserved) || tmo_fire;

  assign wr_set       = reg_we_i && (reg_addr_i == BIMON_OFF_TMO_SET);
  assign wr_count     = reg_we_i && (reg_addr_i == BIMON_OFF_TMO_COUNT);
  assign wr_lo        = reg_we_i && (reg_addr_i == BIMON_OFF_ERR_LO);
  assign wr_hi        = reg_we_i && (reg_addr_i == BIMON_OFF_ERR_HI);
  assign wr_irq       = reg_we_i && (reg_addr_i == BIMON_OFF_IRQ);
  assign rd_any       = reg_re_i;

  // Bits 5:2 are undefined by contract; they are returned as zero here
  always_comb begin
    irq_word = 16'h0000;
    irq_word[BIMON_IRQ_TMO_BIT] = q.timeout_error_flag;
    irq_word[BIMON_IRQ_RSV_BIT] = q.reserved_space_error_flag;
  end

  // ----------------------------------------------------------------------
  // Timeout counter
  // ----------------------------------------------------------------------
  bimon_timer u_timer (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .clear_i  (rtc_clr || start_timing),
    .run_i    (timing),
    .wr_i     (wr_count),
    .wdata_i  (reg_wdata_i),
    .limit_i  (q.tmo_set),
    .count_o  (tmo_count),
    .hit_o    (tmo_hit)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_q          = q;
    next_q.rtc_sync = {q.rtc_sync[0], rtc_reset_i};
    next_q.rsp      = '0;
    next_q.abort    = 1'b0;
    next_q.rdata    = BIMON_RST_RDATA;

    // Request sequencing
    unique case (q.state)
      BIMON_IDLE: begin
        if (accept) begin
          next_q.req = cpu_req_i;
          if (acc_reserved) begin
            next_q.state = BIMON_DUMMY;
          end else begin
            next_q.state = BIMON_FWD;
          end
        end
      end
      BIMON_FWD: begin
        if (ext_ready_i) begin
          next_q.state    = BIMON_IDLE;
          next_q.rsp.done = 1'b1;
        end else if (tmo_fire) begin
          next_q.state         = BIMON_IDLE;
          next_q.abort         = 1'b1;
          next_q.rsp.done      = 1'b1;
          next_q.rsp.bus_error = 1'b1;
        end
      end
      BIMON_DUMMY: begin
        // Target never sees the cycle; core gets a dummy completion
        next_q.state         = BIMON_IDLE;
        next_q.rsp.done      = 1'b1;
        next_q.rsp.bus_error = !q.req.write;
      end
    endcase

    // Software writes
    if (wr_set) begin
      next_q.tmo_set = reg_wdata_i;
    end
    if (wr_lo) begin
      next_q.fault_address[15:0] = reg_wdata_i;
    end
    if (wr_hi) begin
      next_q.fault_address[31:16] = reg_wdata_i;
    end
    // Write one to clear; a new event in the same cycle wins below
    if (wr_irq && reg_wdata_i[BIMON_IRQ_TMO_BIT]) begin
      next_q.timeout_error_flag = 1'b0;
    end
    if (wr_irq && reg_wdata_i[BIMON_IRQ_RSV_BIT]) begin
      next_q.reserved_space_error_flag = 1'b0;
    end

    // Hardware capture; each new error overwrites the address
    if (capture) begin
      if (accept) begin
        next_q.fault_address[15:0]  = cpu_req_i.addr[15:0];
        next_q.fault_address[31:16] = cpu_req_i.addr[31:16];
      end else begin
        next_q.fault_address[15:0]  = q.req.addr[15:0];
        next_q.fault_address[31:16] = q.req.addr[31:16];
      end
    end
    if (tmo_fire) begin
      next_q.timeout_error_flag = 1'b1;
    end
    if (accept && acc_reserved) begin
      next_q.reserved_space_error_flag = 1'b1;
    end

    // Read data for the following cycle only
    if (rd_any) begin
      unique case (reg_addr_i)
        BIMON_OFF_TMO_SET:   next_q.rdata = q.tmo_set;
        BIMON_OFF_TMO_COUNT: next_q.rdata = tmo_count;
        BIMON_OFF_ERR_LO:    next_q.rdata = q.fault_address[15:0];
        BIMON_OFF_ERR_HI:    next_q.rdata = q.fault_address[31:16];
        BIMON_OFF_IRQ:       next_q.rdata = irq_word;
        default:             next_q.rdata = BIMON_RST_RDATA;
      endcase
    end

    // RTC reset clears the whole register set, software writes included
    if (rtc_clr) begin
      next_q.tmo_set                   = BIMON_RST_TMO_SET;
      next_q.fault_address             = BIMON_RST_ERR_ADDR;
      next_q.timeout_error_flag        = 1'b0;
      next_q.reserved_space_error_flag = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata_o         = q.rdata;
  assign cpu_ready_o         = (q.state == BIMON_IDLE);
  assign cpu_rsp_o           = q.rsp;
  assign fwd_valid_o         = (q.state == BIMON_FWD);
  assign fwd_req_o           = q.req;
  assign fwd_abort_o         = q.abort;
  assign maskable_irq_line_o = q.timeout_error_flag
                             | q.reserved_space_error_flag;

endmodule : bimon_top
`default_nettype wire
